// ===== hdl/alm_pkg.sv
// Package for the alarm manager: classes, actions, register map and timing constants
package alm_pkg;
  // Alarm class codes
  typedef enum logic [1:0] {
    ALM_CLASS_OFF = 2'h0,
    ALM_CLASS_A = 2'h1,
    ALM_CLASS_B = 2'h2,
    ALM_CLASS_C = 2'h3
  } alm_class_t;
  // Alarm action codes
  typedef enum logic [1:0] {
    ALM_ACT_WARN = 2'h0,
    ALM_ACT_STOP = 2'h1,
    ALM_ACT_REDUCED = 2'h2
  } alm_action_t;
  // Register byte offsets
  localparam logic [7:0] ALM_REG_CTRL = 8'h00;
  localparam logic [7:0] ALM_REG_CFG = 8'h04;
  localparam logic [7:0] ALM_REG_DELAY = 8'h08;
  localparam logic [7:0] ALM_REG_THRESH = 8'h0c;
  localparam logic [7:0] ALM_REG_STATUS = 8'h10;
  localparam logic [7:0] ALM_REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] ALM_REG_IRQ_CLR = 8'h18;
  localparam logic [7:0] ALM_REG_IRQ_EN = 8'h1c;
  localparam logic [7:0] ALM_REG_MEAS = 8'h20;
  // Control register fields
  localparam int ALM_CTRL_ACK_BIT = 0;
  localparam int ALM_CTRL_BLOCK_BIT = 1;
  localparam int ALM_CTRL_RUN_BIT = 2;
  // Config register fields
  localparam int ALM_CFG_CLASS_LSB = 0;
  localparam int ALM_CFG_ACT_LSB = 2;
  localparam int ALM_CFG_ANA_BIT = 4;
  // Status register fields
  localparam int ALM_ST_ACTIVE_BIT = 0;
  localparam int ALM_ST_CANCEL_BIT = 1;
  localparam int ALM_ST_ACKED_BIT = 2;
  localparam int ALM_ST_BLOCKED_BIT = 3;
  localparam int ALM_ST_STOP_BIT = 4;
  localparam int ALM_ST_REDUCED_BIT = 5;
  localparam int ALM_ST_WARN_BIT = 6;
  // Interrupt event bits
  localparam int ALM_EV_RAISE_BIT = 0;
  localparam int ALM_EV_CANCEL_BIT = 1;
  localparam int ALM_EV_CLEAR_BIT = 2;
  localparam int ALM_EV_W = 3;
  // Reset values: supply fan alarm is class B, stop action, digital source
  localparam logic [1:0] ALM_CLASS_RST = 2'h2;
  localparam logic [1:0] ALM_ACT_RST = 2'h1;
  // Onset delay of the supply fan alarm
  localparam int ALM_DELAY_S = 120;
  localparam longint ALM_CLK_HZ = 20000000;
  localparam longint ALM_DELAY_CYC = ALM_DELAY_S * ALM_CLK_HZ;
  localparam int ALM_TIMER_W = 32;
endpackage : alm_pkg

// ===== hdl/alm_manager.sv
// Supply fan malfunction alarm supervision with APB register access
`timescale 1ns/1ns
`default_nettype none
module alm_manager #(
  parameter longint DELAY_CYC = alm_pkg::ALM_DELAY_CYC,
  parameter int MEAS_W = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic supply_fan_flow_input,
  input wire logic unit_running,
  input wire logic [MEAS_W-1:0] meas_value,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic alarm_out,
  output logic stop_req,
  output logic reduced_req
);
  import alm_pkg::*;

  // Alarm life cycle states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ACTIVE = 4'h2,
    ST_ACKED = 4'h4,
    ST_CANCEL = 4'h8
  } alm_state_t;

  alm_state_t state_r;
  alm_state_t state_nxt;
  logic [1:0] class_r;
  logic [1:0] action_r;
  logic ana_r;
  logic block_r;
  logic run_r;
  logic [ALM_TIMER_W-1:0] delay_r;
  logic [MEAS_W-1:0] thresh_r;
  logic [ALM_TIMER_W-1:0] onset_cnt_r;
  logic [ALM_EV_W-1:0] irq_stat_r;
  logic [ALM_EV_W-1:0] irq_en_r;
  logic [ALM_EV_W-1:0] irq_clr;
  logic [ALM_EV_W-1:0] ev;
  logic cause;
  logic onset_done;
  logic ack_pulse;
  logic latched;
  logic manual_cls;
  logic effect;
  logic wr_en;
  logic ana_cause;
  logic dig_cause;
  logic [31:0] status_word;
  logic [31:0] rd_data;
  logic addr_ok;

  // Write strobe; the access completes on the first access cycle
  assign wr_en = psel && penable && pwrite;

  // Address decode; anything off the map answers with an error
  always_comb begin
    unique case (paddr)
      ALM_REG_CTRL,
      ALM_REG_CFG,
      ALM_REG_DELAY,
      ALM_REG_THRESH,
      ALM_REG_STATUS,
      ALM_REG_IRQ_STAT,
      ALM_REG_IRQ_CLR,
      ALM_REG_IRQ_EN,
      ALM_REG_MEAS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Acknowledge pulse and interrupt clear, both write-one strobes
  assign ack_pulse = wr_en && (paddr == ALM_REG_CTRL) && pwdata[ALM_CTRL_ACK_BIT];
  assign irq_clr = (wr_en && (paddr == ALM_REG_IRQ_CLR)) ? pwdata[ALM_EV_W-1:0] : '0;

  // Analogue cause: value strictly below threshold, no band around it
  assign ana_cause = (meas_value < thresh_r);

  // Digital cause: normally open switch still open, so no air flow
  assign dig_cause = !supply_fan_flow_input;

  // Either source counts only while supervision and the unit both run
  assign cause = run_r && unit_running && (ana_r ? ana_cause : dig_cause);

  // Onset reached, class and latch decode
  assign onset_done = (onset_cnt_r >= delay_r);
  assign manual_cls = (class_r == ALM_CLASS_A) || (class_r == ALM_CLASS_B);
  assign latched = (state_r != ST_IDLE);

  // Alarm in effect on the machine only while raised and not blocked
  assign effect = latched && !block_r;

  // Alarm class, reset to the supply fan default
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      class_r <= ALM_CLASS_RST;
    end else if (wr_en && paddr == ALM_REG_CFG) begin
      class_r <= pwdata[ALM_CFG_CLASS_LSB +: 2];
    end
  end

  // Alarm action, reset to stop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      action_r <= ALM_ACT_RST;
    end else if (wr_en && paddr == ALM_REG_CFG) begin
      action_r <= pwdata[ALM_CFG_ACT_LSB +: 2];
    end
  end

  // Cause source select: switch or analogue value
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ana_r <= 1'b0;
    end else if (wr_en && paddr == ALM_REG_CFG) begin
      ana_r <= pwdata[ALM_CFG_ANA_BIT];
    end
  end

  // Operator block flag
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      block_r <= 1'b0;
    end else if (wr_en && paddr == ALM_REG_CTRL) begin
      block_r <= pwdata[ALM_CTRL_BLOCK_BIT];
    end
  end

  // Supervision enable; a control write must keep it set to stay armed
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      run_r <= 1'b1;
    end else if (wr_en && paddr == ALM_REG_CTRL) begin
      run_r <= pwdata[ALM_CTRL_RUN_BIT];
    end
  end

  // Onset delay in clock cycles
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      delay_r <= DELAY_CYC[ALM_TIMER_W-1:0];
    end else if (wr_en && paddr == ALM_REG_DELAY) begin
      delay_r <= pwdata;
    end
  end

  // Analogue threshold
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      thresh_r <= '0;
    end else if (wr_en && paddr == ALM_REG_THRESH) begin
      thresh_r <= pwdata[MEAS_W-1:0];
    end
  end

  // Onset timer: counts while cause holds, restarts at once when it drops
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      onset_cnt_r <= '0;
    end else if (!cause || class_r == ALM_CLASS_OFF) begin
      onset_cnt_r <= '0;
    end else if (!onset_done) begin
      onset_cnt_r <= onset_cnt_r + 1'b1;
    end
  end

  // Alarm state transitions
  always_comb begin
    state_nxt = state_r;
    if (class_r == ALM_CLASS_OFF) begin
      state_nxt = ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (cause && onset_done) begin
            state_nxt = ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (!cause) begin
            state_nxt = manual_cls ? ST_CANCEL : ST_IDLE;
          end else if (ack_pulse && manual_cls) begin
            state_nxt = ST_ACKED;
          end
        end
        ST_ACKED: begin
          if (!cause) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_CANCEL: begin
          if (cause && onset_done) begin
            state_nxt = ST_ACTIVE;
          end else if (ack_pulse) begin
            state_nxt = ST_IDLE;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Raise event: alarm leaves idle straight into active
  assign ev[ALM_EV_RAISE_BIT] = (state_r == ST_IDLE) && (state_nxt == ST_ACTIVE);

  // Cancel event: cause gone while the alarm stays latched
  assign ev[ALM_EV_CANCEL_BIT] = (state_r != ST_CANCEL) && (state_nxt == ST_CANCEL);

  // Clear event: alarm back to idle by any path
  assign ev[ALM_EV_CLEAR_BIT] = (state_r != ST_IDLE) && (state_nxt == ST_IDLE);

  // Sticky status, set wins over clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | ev;
    end
  end

  // Interrupt enable mask
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_en_r <= '0;
    end else if (wr_en && paddr == ALM_REG_IRQ_EN) begin
      irq_en_r <= pwdata[ALM_EV_W-1:0];
    end
  end

  // Level interrupt from the next sticky status
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat_r & ~irq_clr | ev) & irq_en_r);
    end
  end

  // Alarm indication, whatever the action
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      alarm_out <= 1'b0;
    end else begin
      alarm_out <= (state_nxt != ST_IDLE);
    end
  end

  // Shutdown request while raised and not blocked
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stop_req <= 1'b0;
    end else begin
      stop_req <= (state_nxt != ST_IDLE) && !block_r &&
                  (action_r == ALM_ACT_STOP);
    end
  end

  // Reduced speed request while raised and not blocked
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reduced_req <= 1'b0;
    end else begin
      reduced_req <= (state_nxt != ST_IDLE) && !block_r &&
                     (action_r == ALM_ACT_REDUCED);
    end
  end

  // Status word for software
  always_comb begin
    status_word = '0;
    status_word[ALM_ST_ACTIVE_BIT] = (state_r == ST_ACTIVE);
    status_word[ALM_ST_CANCEL_BIT] = (state_r == ST_CANCEL);
    status_word[ALM_ST_ACKED_BIT] = (state_r == ST_ACKED);
    status_word[ALM_ST_BLOCKED_BIT] = block_r;
    status_word[ALM_ST_STOP_BIT] = effect && (action_r == ALM_ACT_STOP);
    status_word[ALM_ST_REDUCED_BIT] = effect && (action_r == ALM_ACT_REDUCED);
    status_word[ALM_ST_WARN_BIT] = latched;
  end

  // Read data mux
  always_comb begin
    rd_data = '0;
    unique case (paddr)
      ALM_REG_CTRL: begin
        rd_data[ALM_CTRL_BLOCK_BIT] = block_r;
        rd_data[ALM_CTRL_RUN_BIT] = run_r;
      end
      ALM_REG_CFG: begin
        rd_data[ALM_CFG_CLASS_LSB +: 2] = class_r;
        rd_data[ALM_CFG_ACT_LSB +: 2] = action_r;
        rd_data[ALM_CFG_ANA_BIT] = ana_r;
      end
      ALM_REG_DELAY: rd_data = delay_r;
      ALM_REG_THRESH: rd_data[MEAS_W-1:0] = thresh_r;
      ALM_REG_STATUS: rd_data = status_word;
      ALM_REG_IRQ_STAT: rd_data[ALM_EV_W-1:0] = irq_stat_r;
      ALM_REG_IRQ_EN: rd_data[ALM_EV_W-1:0] = irq_en_r;
      ALM_REG_MEAS: rd_data[MEAS_W-1:0] = meas_value;
      default: rd_data = '0;
    endcase
  end

  // Ready one cycle after setup, so no wait states
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Error answer for addresses off the map
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // Read data captured at setup, held until the next read
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_data;
    end
  end
endmodule : alm_manager
`default_nettype wire

// ===== bench/alm_manager_monitor.sv
// Assertion checker for the alarm manager ports
`timescale 1ns/1ns
`default_nettype none
module alm_manager_monitor #(
  parameter longint DELAY_CYC = 5
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic unit_running,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic alarm_out,
  input wire logic stop_req,
  input wire logic reduced_req
);
  logic [31:0] run_cnt;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // Consecutive cycles with the unit running, saturating
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !unit_running) run_cnt <= 32'h0;
    else if (!run_cnt[31]) run_cnt <= run_cnt + 32'h1;
  end
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_read: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("error read not zero");
  a_stop_alarm: assert property (stop_req |-> alarm_out && !reduced_req)
    else $error("stop without alarm");
  a_reduced_alarm: assert property (reduced_req |-> alarm_out)
    else $error("reduced without alarm");
  a_onset_delay: assert property ($rose(alarm_out) |-> run_cnt >= DELAY_CYC)
    else $error("alarm before delay");
  a_reset_clear: assert property (disable iff (1'b0)
    sys_rst |=> !alarm_out && !stop_req && !reduced_req && !irq)
    else $error("outputs set after reset");
  c_raise: cover property ($rose(alarm_out));
  c_err: cover property (pslverr);
  c_reduced: cover property ($rose(reduced_req));
  c_irq: cover property ($rose(irq));
endmodule // alm_manager_monitor

bind alm_manager alm_manager_monitor #(.DELAY_CYC(DELAY_CYC)) u_mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .unit_running(unit_running),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .alarm_out(alarm_out),
  .stop_req(stop_req), .reduced_req(reduced_req)
);
`default_nettype wire

// ===== bench/alm_plant.sv
// Plant model: unit run state, supply fan pressure switch and measurement
`timescale 1ns/1ns
`default_nettype none
module alm_plant (
  input wire logic clk_sys,
  input wire logic run_cmd,
  input wire logic fault,
  input wire logic [15:0] meas_cmd,
  output logic supply_fan_flow_input,
  output logic unit_running,
  output logic [15:0] meas_value
);
  // Normally open switch closes only while running with air flow
  always_ff @(posedge clk_sys) begin
    supply_fan_flow_input <= run_cmd & ~fault;
    unit_running <= run_cmd;
    meas_value <= meas_cmd;
  end
endmodule // alm_plant
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the alarm manager
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import alm_pkg::*;
  localparam longint DLY = 5;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run_cmd = 1'b1, fault = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] meas_cmd = 16'h64, meas_value;
  logic pready, pslverr, irq, alarm_out, stop_req, reduced_req, flow, running, er;
  int errors = 0, compares = 0, cyc = 0;
  alm_manager #(.DELAY_CYC(DLY)) i_alm_manager (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .supply_fan_flow_input(flow), .unit_running(running), .meas_value(meas_value),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .alarm_out(alarm_out), .stop_req(stop_req), .reduced_req(reduced_req));
  alm_plant i_alm_plant (.clk_sys(clk_sys), .run_cmd(run_cmd), .fault(fault),
    .meas_cmd(meas_cmd), .supply_fan_flow_input(flow), .unit_running(running),
    .meas_value(meas_value));
  // Clock and hang guard
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkf(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  // APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Apply a cause and wait for the alarm with a bound
  task automatic raise(input logic ana);
    int n;
    n = 0;
    @(posedge clk_sys);
    if (ana) meas_cmd <= 16'h63;
    else fault <= 1'b1;
    repeat (DLY) @(posedge clk_sys);
    chkf("early", 1'b0, alarm_out);
    while (alarm_out !== 1'b1 && n < 10) begin
      @(posedge clk_sys);
      n++;
    end
    chkf("alarm", 1'b1, alarm_out);
  endtask
  task automatic off();
    @(posedge clk_sys);
    fault <= 1'b0;
    meas_cmd <= 16'h64;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic t_rst();
    rdc(ALM_REG_CTRL, 32'h4);
    rdc(ALM_REG_CFG, 32'h6);
    rdc(ALM_REG_STATUS, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chkf("slverr", 1'b1, er);
    chk("unmapped", 32'h0, rd);
    $display("done reset");
  endtask
  task automatic t_latch();
    raise(1'b0);
    chkf("stop", 1'b1, stop_req);
    rdc(ALM_REG_STATUS, 32'h51);
    off();
    rdc(ALM_REG_STATUS, 32'h52);
    wr(ALM_REG_CTRL, 32'h5);
    rdc(ALM_REG_STATUS, 32'h0);
    chkf("alarm", 1'b0, alarm_out);
    $display("done latch");
  endtask
  task automatic t_ack();
    wr(ALM_REG_CFG, 32'h5);
    raise(1'b0);
    wr(ALM_REG_CTRL, 32'h5);
    rdc(ALM_REG_STATUS, 32'h54);
    off();
    chkf("alarm", 1'b0, alarm_out);
    $display("done ack");
  endtask
  task automatic t_auto();
    wr(ALM_REG_CFG, 32'hb);
    raise(1'b0);
    chkf("reduced", 1'b1, reduced_req);
    chkf("stop", 1'b0, stop_req);
    wr(ALM_REG_CTRL, 32'h6);
    repeat (2) @(posedge clk_sys);
    chkf("blocked", 1'b0, reduced_req);
    chkf("alarm", 1'b1, alarm_out);
    wr(ALM_REG_CTRL, 32'h4);
    repeat (2) @(posedge clk_sys);
    chkf("unblocked", 1'b1, reduced_req);
    off();
    chkf("alarm", 1'b0, alarm_out);
    $display("done auto");
  endtask
  task automatic t_quiet();
    wr(ALM_REG_CFG, 32'h0);
    fault <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chkf("off class", 1'b0, alarm_out);
    wr(ALM_REG_CFG, 32'h3);
    repeat (10) @(posedge clk_sys);
    chkf("warn", 1'b1, alarm_out);
    chkf("stop", 1'b0, stop_req);
    chkf("reduced", 1'b0, reduced_req);
    off();
    $display("done quiet");
  endtask
  task automatic t_ana();
    wr(ALM_REG_THRESH, 32'h64);
    wr(ALM_REG_CFG, 32'h13);
    repeat (20) @(posedge clk_sys);
    chkf("at threshold", 1'b0, alarm_out);
    raise(1'b1);
    off();
    rdc(ALM_REG_MEAS, 32'h64);
    chkf("alarm", 1'b0, alarm_out);
    $display("done analogue");
  endtask
  task automatic t_irq();
    rdc(ALM_REG_IRQ_STAT, 32'h7);
    wr(ALM_REG_IRQ_EN, 32'h1);
    repeat (2) @(posedge clk_sys);
    chkf("irq", 1'b1, irq);
    wr(ALM_REG_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk_sys);
    chkf("masked", 1'b0, irq);
    wr(ALM_REG_IRQ_CLR, 32'h7);
    rdc(ALM_REG_IRQ_STAT, 32'h0);
    $display("done irq");
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_rst();
    t_latch();
    t_ack();
    t_auto();
    t_quiet();
    t_ana();
    t_irq();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
